// ==== vip_pkg.sv ====
// package for the video input port front end
// What this block does
// - output frame rate equals input frame rate
// - optional eye sync output per frame
// - vsync stall halts sequencer, leds off
// - frame mask blocks new frames, holds image
// - programmable mask polarity, default active high
// - six parallel transfer formats supported
// - 4:2:2 luma each pixel, chroma alternates
// - serial 888 three clocks per pixel
// - serial 4:2:2 two clocks per pixel
// - serial clock fixed, change announced first
// - lane 0 always used, lanes 1-3 optional
// - video mode only, commands rejected
// - header crc/ecc check, payload checksum reported
// - lane count strapped at reset release
// - startup indicator floats, high, then low
// - no video accepted before initialization done
package vip_pkg;

    // ------------------------------------------------------------
    // pixel formats
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VIP_FMT_888    = 3'h0,
        VIP_FMT_666    = 3'h1,
        VIP_FMT_565    = 3'h2,
        VIP_FMT_422    = 3'h3,
        VIP_FMT_S888   = 3'h4,
        VIP_FMT_S422   = 3'h5
    } vip_fmt_t;

    // ------------------------------------------------------------
    // startup states, gray along the path
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VIP_ST_FLOAT = 2'h0,
        VIP_ST_INIT  = 2'h1,
        VIP_ST_READY = 2'h3
    } vip_start_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] c2;
    } vip_pix_t;

    typedef struct packed {
        logic       err_hdr;
        logic       err_sum;
        logic       err_cmd;
    } vip_lerr_t;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int unsigned VIP_CLK_HZ      = 40_000_000;
    localparam int unsigned VIP_VS_TMO_MS   = 100;
    localparam int unsigned VIP_VS_TMO_CYC  = VIP_CLK_HZ / 1000 * VIP_VS_TMO_MS;
    localparam int unsigned VIP_BOOT_US     = 1000;
    localparam int unsigned VIP_BOOT_CYC    = VIP_CLK_HZ / 1_000_000 * VIP_BOOT_US;
    localparam logic [1:0]  VIP_PH_LAST3    = 2'h2;
    localparam logic [1:0]  VIP_PH_LAST2    = 2'h1;
    localparam logic [1:0]  VIP_PH_ZERO     = 2'h0;
    localparam logic [1:0]  VIP_PH_ONE      = 2'h1;
    localparam logic        VIP_MASK_POL_RST = 1'b1;
    localparam int unsigned VIP_LANES_W     = 2;
    localparam logic [7:0]  VIP_DT_VIDEO_LO = 8'h0E;
    localparam logic [7:0]  VIP_DT_VIDEO_HI = 8'h3E;
    localparam logic [7:0]  VIP_DT_DCS_LO   = 8'h05;
    localparam logic [7:0]  VIP_DT_DCS_HI   = 8'h39;
    localparam logic [1:0]  VIP_VC_VIDEO    = 2'h0;

endpackage

// ==== vip_top.sv ====
// video input port: parallel capture, serial packet check and startup
`timescale 1ns/100ps
module vip_top
    import vip_pkg::*;
#(
    parameter int unsigned VS_TMO_CYC = VIP_VS_TMO_CYC,
    parameter int unsigned BOOT_CYC   = VIP_BOOT_CYC
)(
    // system
    input  wire logic              clk,
    input  wire logic              srst,
    // configuration and control
    input  wire vip_fmt_t          fmt_sel,
    input  wire logic              mask_pol,
    input  wire logic              hdr_chk_en,
    input  wire logic              init_done,
    input  wire logic [1:0]        lane_strap,
    // parallel port, pixel clock domain
    input  wire logic              pclk,
    input  wire logic              pix_vsync,
    input  wire logic              pixel_valid_in,
    input  wire logic [23:0]       pixel_bus,
    input  wire logic              frame_mask_in,
    input  wire logic              eye_select_in,
    // serial link, already deserialised on the byte clock
    input  wire logic              link_clk,
    input  wire logic              link_pkt_start,
    input  wire logic [7:0]        link_dt,
    input  wire logic [1:0]        link_vc,
    input  wire logic              link_hdr_bad,
    input  wire logic              link_sum_bad,
    // pixel output, system clock
    output vip_pix_t               pix_out,
    output logic                   pix_out_vld,
    output logic                   frame_start,
    output logic                   eye_sync,
    // status
    output logic [VIP_LANES_W-1:0] lanes_en,
    output logic                   seq_run,
    output logic                   led_en,
    output vip_lerr_t              link_err,
    output logic                   startup_o,
    output logic                   startup_oe_n
);

    // ------------------------------------------------------------
    // pixel clock domain: capture and assembly
    // ------------------------------------------------------------
    logic              p_rst_m_r, p_rst_r;
    logic [1:0]        ph_r;
    vip_pix_t          asm_r;
    vip_pix_t          word_r;
    logic              wtog_r;
    logic              vs_d_r;
    logic              ftog_r;
    logic              eye_p_r;
    logic              ready_m_r, ready_p_r;
    logic [1:0]        ph_last;
    logic              ph_end;
    vip_start_t        st_r;

    // reset brought into the pixel domain
    always_ff @(posedge pclk)
    begin
        p_rst_m_r <= srst;
        p_rst_r   <= p_rst_m_r;
    end

    // readiness into the pixel domain, level crossing
    always_ff @(posedge pclk)
    begin
        ready_m_r <= (st_r == VIP_ST_READY);
        ready_p_r <= ready_m_r;
    end

    always_comb
    begin
        ph_last = (fmt_sel == VIP_FMT_S888) ? VIP_PH_LAST3 :
                  (fmt_sel == VIP_FMT_S422) ? VIP_PH_LAST2 : VIP_PH_ZERO;
        ph_end  = (ph_r == ph_last);
    end

    // component phase counter, restarts at each frame
    always_ff @(posedge pclk)
    begin
        if (p_rst_r || (pix_vsync && !vs_d_r))
            ph_r <= VIP_PH_ZERO;
        else if (pixel_valid_in && ready_p_r)
            ph_r <= ph_end ? VIP_PH_ZERO : ph_r + VIP_PH_ONE;
    end

    // assembly per format; wide formats pass through in one clock
    always_ff @(posedge pclk)
    begin
        if (p_rst_r)
        begin
            asm_r  <= '0;
            word_r <= '0;
            wtog_r <= 1'b0;
        end
        else if (pixel_valid_in && ready_p_r)
        begin
            case (fmt_sel)
                VIP_FMT_888, VIP_FMT_422:
                    word_r <= pixel_bus; // y on c0..; cb/cr alternate, shared downstream
                VIP_FMT_666:
                    word_r <= {pixel_bus[17:12], 2'h0, pixel_bus[11:6], 2'h0,
                               pixel_bus[5:0], 2'h0};
                VIP_FMT_565:
                    word_r <= {pixel_bus[15:11], 3'h0, pixel_bus[10:5], 2'h0,
                               pixel_bus[4:0], 3'h0};
                VIP_FMT_S888, VIP_FMT_S422:
                begin
                    case (ph_r)
                        VIP_PH_ZERO: asm_r.c0 <= pixel_bus[7:0];
                        VIP_PH_ONE:  asm_r.c1 <= pixel_bus[7:0];
                        default:     asm_r.c2 <= pixel_bus[7:0];
                    endcase
                    if (ph_end)
                    begin
                        if (fmt_sel == VIP_FMT_S888)
                            word_r <= {asm_r.c0, asm_r.c1, pixel_bus[7:0]};
                        else
                            word_r <= {asm_r.c0, pixel_bus[7:0], 8'h00};
                    end
                end
                default:
                    word_r <= word_r;
            endcase
            if (ph_end)
                wtog_r <= ~wtog_r;
        end
    end

    // frame start toggle and eye latch at vsync rise
    always_ff @(posedge pclk)
    begin
        if (p_rst_r)
        begin
            vs_d_r  <= 1'b0;
            ftog_r  <= 1'b0;
            eye_p_r <= 1'b0;
        end
        else
        begin
            vs_d_r <= pix_vsync;
            if (pix_vsync && !vs_d_r)
            begin
                ftog_r  <= ~ftog_r;
                eye_p_r <= eye_select_in;
            end
        end
    end

    // ------------------------------------------------------------
    // crossings into clk: three stages; word, frame and eye change taken when 2 and 3 agree, mask taken from stage 3
    // ------------------------------------------------------------
    logic [2:0] w_s_r, f_s_r, e_s_r, m_s_r;
    logic       w_seen_r, f_seen_r;
    logic       mask_q_r;

    always_ff @(posedge clk)
    begin
        w_s_r <= {w_s_r[1:0], wtog_r};
        f_s_r <= {f_s_r[1:0], ftog_r};
        e_s_r <= {e_s_r[1:0], eye_p_r};
        m_s_r <= {m_s_r[1:0], frame_mask_in};
    end

    // word is stable for many clk cycles since pclk is far slower per pixel
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            w_seen_r    <= 1'b0;
            f_seen_r    <= 1'b0;
            pix_out     <= '0;
            pix_out_vld <= 1'b0;
            frame_start <= 1'b0;
            mask_q_r    <= 1'b0;
        end
        else
        begin
            pix_out_vld <= 1'b0;
            frame_start <= 1'b0;
            if (w_s_r[2] == w_s_r[1] && w_s_r[2] != w_seen_r)
            begin
                w_seen_r <= w_s_r[2];
                if (!mask_q_r)
                begin
                    pix_out     <= word_r;
                    pix_out_vld <= 1'b1; // one output per assembled pixel, no rate change
                end
            end
            if (f_s_r[2] == f_s_r[1] && f_s_r[2] != f_seen_r)
            begin
                f_seen_r    <= f_s_r[2];
                frame_start <= 1'b1;
                // mask sampled at frame boundary only, source holds it steady
                mask_q_r    <= (m_s_r[2] == mask_pol);
            end
        end
    end

    // eye sync follows the latched eye select
    always_ff @(posedge clk)
    begin
        if (srst)
            eye_sync <= 1'b0;
        else if (e_s_r[2] == e_s_r[1])
            eye_sync <= e_s_r[2];
    end

    // ------------------------------------------------------------
    // vsync watchdog: sequencer and leds
    // ------------------------------------------------------------
    logic [$clog2(VS_TMO_CYC+1)-1:0] vs_cnt_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            vs_cnt_r <= '0;
            seq_run  <= 1'b0;
            led_en   <= 1'b0;
        end
        else if (f_s_r[2] != f_s_r[1] || st_r != VIP_ST_READY)
            vs_cnt_r <= '0;
        else if (vs_cnt_r == VS_TMO_CYC[$bits(vs_cnt_r)-1:0])
        begin
            seq_run <= 1'b0;
            led_en  <= 1'b0;
        end
        else
        begin
            vs_cnt_r <= vs_cnt_r + 1'b1;
            if (frame_start)
            begin
                seq_run <= 1'b1;
                led_en  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // startup: strap capture and indicator
    // ------------------------------------------------------------
    logic [$clog2(BOOT_CYC+1)-1:0]    boot_r;
    logic                             rst_d_r;

    // lanes latched on the first clock after reset release
    always_ff @(posedge clk)
    begin
        rst_d_r <= srst;
        if (srst)
            lanes_en <= '0;
        else if (rst_d_r)
            lanes_en <= lane_strap;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r         <= VIP_ST_FLOAT;
            boot_r       <= '0;
            startup_o    <= 1'b1;
            startup_oe_n <= 1'b1; // floats, pulled high
        end
        else
        begin
            case (st_r)
                VIP_ST_FLOAT:
                    if (boot_r == BOOT_CYC[$bits(boot_r)-1:0])
                    begin
                        st_r         <= VIP_ST_INIT;
                        startup_oe_n <= 1'b0;
                    end
                    else
                        boot_r <= boot_r + 1'b1;
                VIP_ST_INIT:
                    if (init_done)
                    begin
                        st_r      <= VIP_ST_READY;
                        startup_o <= 1'b0;
                    end
                VIP_ST_READY:
                    st_r <= VIP_ST_READY;
                default:
                    st_r <= VIP_ST_FLOAT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // link domain: packet screening, events back by toggle
    // ------------------------------------------------------------
    logic       l_rst_m_r, l_rst_r;
    logic [2:0] l_tog_r;
    logic [2:0] e0_s_r, e1_s_r, e2_s_r;
    logic [2:0] l_fire;

    always_ff @(posedge link_clk)
    begin
        l_rst_m_r <= srst;
        l_rst_r   <= l_rst_m_r; // one fixed link rate, no rate tracking here
    end

    always_comb
    begin
        l_fire[2] = link_pkt_start && hdr_chk_en && link_hdr_bad;
        l_fire[1] = link_pkt_start && link_sum_bad; // reported, not corrected
        l_fire[0] = link_pkt_start && (link_vc != VIP_VC_VIDEO ||
                    (link_dt >= VIP_DT_DCS_LO && link_dt <= VIP_DT_DCS_HI &&
                     link_dt[3:0] != VIP_DT_VIDEO_LO[3:0])); // pixel codes end in E
    end

    always_ff @(posedge link_clk)
    begin
        if (l_rst_r)
            l_tog_r <= '0;
        else
            l_tog_r <= l_tog_r ^ l_fire;
    end

    always_ff @(posedge clk)
    begin
        e0_s_r <= {e0_s_r[1:0], l_tog_r[0]};
        e1_s_r <= {e1_s_r[1:0], l_tog_r[1]};
        e2_s_r <= {e2_s_r[1:0], l_tog_r[2]};
    end

    // one-cycle error pulses in clk
    always_ff @(posedge clk)
    begin
        if (srst)
            link_err <= '0;
        else
        begin
            link_err.err_cmd <= e0_s_r[2] ^ e0_s_r[1];
            link_err.err_sum <= e1_s_r[2] ^ e1_s_r[1];
            link_err.err_hdr <= e2_s_r[2] ^ e2_s_r[1];
        end
    end

endmodule

// ==== vip_monitor.sv ====
// checker for the video input port top
`timescale 1ns/100ps
module vip_monitor
    import vip_pkg::*;
#(
    parameter int unsigned VS_TMO_CYC = 400,
    parameter int unsigned BOOT_CYC   = 10
)(
    // system
    input wire logic                   clk,
    input wire logic                   srst,
    // watched ports
    input wire logic                   hdr_chk_en,
    input wire logic [1:0]             lane_strap,
    input wire logic                   pix_out_vld,
    input wire logic                   frame_start,
    input wire logic                   seq_run,
    input wire logic                   led_en,
    input wire logic [VIP_LANES_W-1:0] lanes_en,
    input wire vip_lerr_t              link_err,
    input wire logic                   startup_o,
    input wire logic                   startup_oe_n
);
    // --------
    // helpers
    // --------
    logic [31:0] fs_age_r;
    logic [31:0] boot_r;
    logic [1:0]  post_r;
    logic [1:0]  strap_r;

    // cycles since the last frame start, saturating
    always_ff @(posedge clk)
        if (srst || frame_start)
            fs_age_r <= 32'h0;
        else if (fs_age_r != 32'hFFFFFFFF)
            fs_age_r <= fs_age_r + 32'h1;

    // cycles spent floating after reset
    always_ff @(posedge clk)
        if (srst)
            boot_r <= 32'h0;
        else if (startup_oe_n)
            boot_r <= boot_r + 32'h1;

    // age after reset, so the strap compare waits out the sampling
    always_ff @(posedge clk)
        if (srst)
            post_r <= 2'h0;
        else if (post_r != 2'h3)
            post_r <= post_r + 2'h1;

    // strap copy from the first edge out of reset
    always_ff @(posedge clk)
        if (!srst && post_r == 2'h0)
            strap_r <= lane_strap;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_PIX_READY: assert property (pix_out_vld |-> !startup_o && !startup_oe_n)
        else $error("pixel out before ready");
    AST_PIX_GAP: assert property (pix_out_vld |=> !pix_out_vld [*4])
        else $error("pixel pulses too close");
    AST_FS_PULSE: assert property (frame_start |=> !frame_start [*8])
        else $error("frame start repeated");
    AST_RUN_RISE: assert property ($rose(seq_run) |-> frame_start || $past(frame_start))
        else $error("sequencer started without frame");
    AST_LED_RUN: assert property (led_en == seq_run)
        else $error("led and sequencer differ");
    AST_VS_TMO: assert property (fs_age_r > VS_TMO_CYC + 8 |-> !seq_run)
        else $error("sequencer still running without vsync");
    AST_START_FLOAT: assert property (startup_oe_n |-> startup_o)
        else $error("floating indicator not high");
    AST_START_HOLD: assert property (!startup_oe_n && !startup_o |=> !startup_oe_n && !startup_o)
        else $error("ready indicator left low");
    AST_BOOT_LEN: assert property ($fell(startup_oe_n) |-> boot_r >= BOOT_CYC - 1)
        else $error("float phase too short");
    AST_LANES: assert property (post_r == 2'h3 |-> lanes_en == strap_r && $stable(lanes_en))
        else $error("lane count not the strap");
    AST_HDR_EN: assert property (link_err.err_hdr |-> hdr_chk_en)
        else $error("header error while checking off");
    AST_ERR_PULSE: assert property (link_err != 3'h0 |=> link_err == 3'h0)
        else $error("link error longer than a pulse");
endmodule

bind vip_top vip_monitor #(.VS_TMO_CYC(VS_TMO_CYC), .BOOT_CYC(BOOT_CYC)) u_mon (
    .clk(clk), .srst(srst), .hdr_chk_en(hdr_chk_en), .lane_strap(lane_strap),
    .pix_out_vld(pix_out_vld), .frame_start(frame_start), .seq_run(seq_run),
    .led_en(led_en), .lanes_en(lanes_en), .link_err(link_err),
    .startup_o(startup_o), .startup_oe_n(startup_oe_n)
);

// ==== vip_host_model.sv ====
// host video source and link transmitter model
`timescale 1ns/100ps
module vip_host_model (
    // parallel source
    output logic        pclk,
    output logic        pix_vsync,
    output logic        pixel_valid_in,
    output logic [23:0] pixel_bus,
    output logic        frame_mask_in,
    output logic        eye_select_in,
    // link transmitter, any data type or channel, never turns the lane round
    output logic        link_clk,
    output logic        link_pkt_start,
    output logic [7:0]  link_dt,
    output logic [1:0]  link_vc,
    output logic        link_hdr_bad,
    output logic        link_sum_bad
);
    logic [23:0] tx_q[$];

    // pixel clock runs free, slower than six system cycles
    initial
    begin
        {pix_vsync, pixel_valid_in, pixel_bus, frame_mask_in, eye_select_in} = '0;
        {link_clk, link_pkt_start, link_dt, link_vc, link_hdr_bad, link_sum_bad} = '0;
        pclk = 1'b0;
        forever #85 pclk = ~pclk;
    end

    // link clock only runs while link_tick is called, with or without traffic
    task automatic link_tick(input int n);
        repeat (n)
        begin
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
    endtask

    // one header on lane 0, then end of transmission cycles
    task automatic send_pkt(input logic [7:0] dt, input logic [1:0] vc, input logic hb, sb);
        {link_pkt_start, link_dt, link_vc, link_hdr_bad, link_sum_bad} = {1'b1, dt, vc, hb, sb};
        link_tick(1);
        // released lines show the inverse, not a held value
        {link_pkt_start, link_dt, link_vc, link_hdr_bad, link_sum_bad} = {1'b0, ~dt, ~vc, ~hb, ~sb};
        link_tick(3);
    endtask

    // vsync pulse, then queued words with idle gaps between them
    task automatic send_frame(input logic eye, mask);
        @(posedge pclk) #1;
        eye_select_in = eye;
        frame_mask_in = mask;
        pix_vsync     = 1'b1;
        repeat (2) @(posedge pclk) #1;
        pix_vsync = 1'b0;
        while (tx_q.size() != 0)
        begin
            @(posedge pclk) #1;
            pixel_valid_in = 1'b1;
            pixel_bus      = tx_q.pop_front();
            @(posedge pclk) #1;
            pixel_valid_in = 1'b0;
            pixel_bus      = ~pixel_bus;
        end
        repeat (3) @(posedge pclk) #1;
    endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the video input port
`timescale 1ns/100ps
module tb;
    import vip_pkg::*;
    localparam int unsigned TMO = 400;

    logic        clk = 1'b0, srst = 1'b1, mask_pol = 1'b1, hdr_chk_en = 1'b1, init_done = 1'b0;
    vip_fmt_t    fmt_sel = VIP_FMT_888;
    logic [1:0]  lane_strap = 2'h0, link_vc, lanes_en;
    logic        pclk, pix_vsync, pixel_valid_in, frame_mask_in, eye_select_in, link_clk;
    logic        link_pkt_start, link_hdr_bad, link_sum_bad, pix_out_vld, frame_start;
    logic        eye_sync, seq_run, led_en, startup_o, startup_oe_n;
    logic [23:0] pixel_bus, exp_q[$];
    logic [7:0]  link_dt;
    vip_pix_t    pix_out, got_q[$];
    vip_lerr_t   link_err;
    logic [31:0] rng = 32'hA6F5E289;
    logic [15:0] pk_tab [0:6];
    int          num_errors = 0, total_checks = 0, n_fs, n_h, n_s, n_c, i, f;

    vip_top #(.VS_TMO_CYC(TMO), .BOOT_CYC(10)) DUT (.*);
    vip_host_model host (.*);

    always #12.5 clk = ~clk;

    // tally pulses away from the edge that launches them
    always @(negedge clk)
    begin
        if (pix_out_vld === 1'b1)
            got_q.push_back(pix_out);
        n_fs += (frame_start === 1'b1);
        n_h  += (link_err.err_hdr === 1'b1);
        n_s  += (link_err.err_sum === 1'b1);
        n_c  += (link_err.err_cmd === 1'b1);
    end

    // --------
    // helpers
    // --------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // words the port needs for one displayed pixel
    function automatic int wpp(input vip_fmt_t fm);
        return (fm == VIP_FMT_S888) ? 3 : (fm == VIP_FMT_S422) ? 2 : 1;
    endfunction

    // expected pixel k of the frame from the queued words
    function automatic logic [23:0] exp_pix(input vip_fmt_t fm, input int k);
        logic [23:0] a, b, c;
        a = exp_q[k * wpp(fm)];
        b = exp_q[k * wpp(fm) + wpp(fm) - 1];
        c = exp_q[k * wpp(fm) + 1];
        case (fm)
            VIP_FMT_666:  return {a[17:12], 2'h0, a[11:6], 2'h0, a[5:0], 2'h0};
            VIP_FMT_565:  return {a[15:11], 3'h0, a[10:5], 2'h0, a[4:0], 3'h0};
            VIP_FMT_S888: return {a[7:0], c[7:0], b[7:0]};
            VIP_FMT_S422: return {a[7:0], b[7:0], 8'h00};
            default:      return a;
        endcase
    endfunction

    task automatic chk_val(input string nm, input logic [23:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, g);
        total_checks++;
        if (g != e)
        begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait for a startup pin state; a hang ends the run
    task automatic wait_pin(input logic oe_n, o);
        for (i = 0; i < 400 && {startup_oe_n, startup_o} !== {oe_n, o}; i++)
            tick(1);
        if (i == 400)
        begin
            chk_val("startup pins", {oe_n, o}, {startup_oe_n, startup_o});
            report_and_stop();
        end
    endtask

    // random words through one frame, then let the pipeline drain
    task automatic run_frame(input logic eye, mask, input int nw);
        logic [23:0] w;
        got_q = {};
        exp_q = {};
        n_fs  = 0;
        repeat (nw)
        begin
            w = 24'(xs());
            host.tx_q.push_back(w);
            exp_q.push_back(w);
        end
        host.send_frame(eye, mask);
        tick(30);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // --------
    // main sequence
    // --------
    initial
    begin
        logic [15:0] pk;
        logic [1:0]  strap;
        logic        ev;
        pk_tab = '{16'h3E08, 16'h3E49, 16'h0509, 16'h3909, 16'h3E2C, 16'h3E20, 16'h3E1A};
        strap = 2'(xs());
        lane_strap = strap;
        // long enough for edges of the slow clocks as well
        fork
            tick(24);
            host.link_tick(4);
        join
        srst = 1'b0;
        chk_val("float oe_n", 1'b1, startup_oe_n);
        chk_val("float level", 1'b1, startup_o);
        wait_pin(1'b0, 1'b1);
        lane_strap = ~strap;
        run_frame(1'b0, 1'b0, 4);
        chk_cnt("pixels before ready", 0, got_q.size());
        init_done = 1'b1;
        wait_pin(1'b0, 1'b0);
        tick(40);
        chk_val("lanes_en", strap, lanes_en);
        $display("test startup done");
        for (f = 0; f < 6; f++)
        begin
            fmt_sel = vip_fmt_t'(f);
            ev = 1'(xs());
            run_frame(ev, 1'b0, 2 * wpp(fmt_sel));
            chk_cnt("pixels", 2, got_q.size());
            chk_cnt("frame starts", 1, n_fs);
            chk_val("eye_sync", ev, eye_sync);
            chk_val("seq_run", 1'b1, seq_run);
            for (i = 0; i < got_q.size(); i++)
                chk_val("pixel", exp_pix(fmt_sel, i), got_q[i]);
            if (fmt_sel == VIP_FMT_S422 && got_q.size() != 0)
                chk_val("chroma pad", 8'h00, got_q[0].c2);
        end
        $display("test formats done");
        fmt_sel = VIP_FMT_888;
        for (f = 0; f < 3; f++)
        begin
            mask_pol = (f == 0);
            run_frame(1'b0, f != 1, 2);
            chk_cnt("masked pixels", (f == 2) ? 2 : 0, got_q.size());
        end
        mask_pol = 1'b1;
        $display("test mask done");
        tick(TMO + 20);
        chk_val("seq_run idle", 1'b0, seq_run);
        chk_val("led_en idle", 1'b0, led_en);
        run_frame(1'b1, 1'b0, 1);
        chk_val("led_en resumed", 1'b1, led_en);
        $display("test vsync loss done");
        // link reset stages need edges before the first packet counts
        host.link_tick(4);
        for (f = 0; f < 7; f++)
        begin
            pk = pk_tab[f];
            hdr_chk_en = pk[3];
            {n_h, n_s, n_c} = '0;
            host.send_pkt(pk[15:8], pk[7:6], pk[5], pk[4]);
            tick(12);
            chk_cnt("header errors", pk[2], n_h);
            chk_cnt("checksum errors", pk[1], n_s);
            chk_cnt("rejected packets", pk[0], n_c);
        end
        $display("test link done");
        report_and_stop();
    end
endmodule
